// [hw/fimp_flash_ctrl.sv]
`timescale 1ns/100ps
`include "fimp_consts.svh"

module fimp_flash_ctrl (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // register/memory port, shared by cpu and monitor host
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  // pins sampled at the mode latch
  input  wire logic        irq_high_voltage,
  input  wire logic        irq_level,
  input  wire logic        reset_pin_level,
  input  wire logic        serial_link_pin,
  input  wire logic        mode_strap_a,
  input  wire logic        mode_strap_b,
  input  wire logic        mode_strap_c,
  input  wire logic        mode_strap_d,
  // status
  output logic             mode_latched,
  output logic             monitor_mode,
  output logic             hv_entry,
  output logic             pll_enable,
  output logic             port_reset_hold,
  output logic      [6:0]  latched_straps,
  output logic             flash_busy,
  output logic             serial_baud_tick
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    fimp_pkg::fimp_seq_e st;
    logic [3:0]          ctrl;
    logic                err;
    logic                busy;
    logic                tgt_ok;
    logic [15:0]         tgt;
    logic [15:0]         cnt;
    logic [15:0]         last;
    logic [7:0]          rdata;
    logic [11:0]         baud;
    logic                tick;
  } fimp_core_s;

  fimp_core_s q, d;

  // the array is kept apart from the state struct: copying 32 kB
  // through a combinational block every cycle would cripple simulation
  logic [7:0] mem [0:`FIMP_ARRAY_BYTES-1];
  logic        mem_we;
  logic [15:0] mem_widx;
  logic [7:0]  mem_wd;

  fimp_pkg::fimp_pins_s pins;
  fimp_pkg::fimp_mode_s mode;

  logic        acc_flash;
  logic [15:0] acc_idx;
  logic [7:0]  acc_rd;
  logic [7:0]  prot_val;
  logic        prot_active;
  logic        blank_vec;
  logic        acc_prot;
  logic        tgt_prot;
  logic        ctrl_hit;
  logic        rom_hit;

  localparam logic [11:0] BAUD_LAST = 12'(`FIMP_BAUD_DIV - 1);

  // ----------------------------------------------------------------
  // mode latch
  // ----------------------------------------------------------------
  assign pins = '{irq_high_voltage: irq_high_voltage,
                  irq_level:        irq_level,
                  reset_pin_level:  reset_pin_level,
                  serial_link_pin:  serial_link_pin,
                  mode_strap_a:     mode_strap_a,
                  mode_strap_b:     mode_strap_b,
                  mode_strap_c:     mode_strap_c,
                  mode_strap_d:     mode_strap_d};

  // both vector bytes erased means the whole array is blank
  assign blank_vec = (mem[`FIMP_RVEC_HI_IDX] == `FIMP_ERASED)
                   & (mem[`FIMP_RVEC_LO_IDX] == `FIMP_ERASED);

  fimp_mode_latch u_mode (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .pins      (pins),
    .blank_vec (blank_vec),
    .mode      (mode)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  always_comb begin
    acc_flash = 1'b0;
    acc_idx   = 16'h0000;
    if (bus_addr >= `FIMP_USER_BASE &&
        bus_addr <= `FIMP_USER_TOP) begin
      acc_flash = 1'b1;
      acc_idx   = bus_addr - `FIMP_USER_BASE;
    end else if (bus_addr >= `FIMP_VEC_BASE) begin
      acc_flash = 1'b1;
      acc_idx   = `FIMP_VEC_IDX + (bus_addr - `FIMP_VEC_BASE);
    end else if (bus_addr == `FIMP_PROT_ADDR) begin
      acc_flash = 1'b1;
      acc_idx   = `FIMP_PROT_IDX;
    end
  end

  assign ctrl_hit = (bus_addr == `FIMP_CTRL_ADDR);
  // monitor firmware area is read-only; writes there do nothing
  assign rom_hit  = (bus_addr >= `FIMP_ROM_BASE) &&
                    (bus_addr <= `FIMP_ROM_TOP);
  assign acc_rd   = mem[acc_idx];

  // ----------------------------------------------------------------
  // protection
  // ----------------------------------------------------------------
  // the protect value is a flash byte, so it survives reset and can
  // only be returned to 8'hFF by an erase that protection allows
  assign prot_val    = mem[`FIMP_PROT_IDX];
  assign prot_active = (prot_val != `FIMP_PROT_OFF);

  // region starts at the selected page and runs to the top, covering
  // the vectors and the protect byte itself
  assign acc_prot = !mode.monitor && prot_active &&
                    (acc_idx[15] ||
                     acc_idx[14:0] >= {prot_val, 7'h00});
  assign tgt_prot = !mode.monitor && prot_active &&
                    (q.tgt[15] ||
                     q.tgt[14:0] >= {prot_val, 7'h00});

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    d        = q;
    d.tick   = 1'b0;
    mem_we   = 1'b0;
    mem_widx = acc_idx;
    mem_wd   = `FIMP_ERASED;

    // raised-voltage entry divides the core clock by FIMP_BAUD_DIV to time the link
    if (mode.monitor && mode.hv_entry) begin
      if (q.baud == BAUD_LAST) begin
        d.baud = 12'h000;
        d.tick = 1'b1;
      end else begin
        d.baud = q.baud + 12'h001;
      end
    end else begin
      d.baud = 12'h000;
    end

    case (q.st)
      fimp_pkg::SEQ_IDLE: begin
        if (bus_wr && mode.done && ctrl_hit) begin
          d.ctrl = bus_wdata[3:0];
          d.err  = 1'b0;
          if (bus_wdata[`FIMP_CTRL_ERASE] &&
              bus_wdata[`FIMP_CTRL_HVEN]) begin
            if (bus_wdata[`FIMP_CTRL_MASS]) begin
              // any protection blocks a user-mode mass erase
              if (!mode.monitor && prot_active) begin
                d.err = 1'b1;
              end else begin
                d.st   = fimp_pkg::SEQ_ERASE;
                d.busy = 1'b1;
                d.cnt  = 16'h0000;
                d.last = `FIMP_LAST_IDX;
              end
            end else if (!q.tgt_ok || q.tgt[15]) begin
              // vectors and protect byte are not in any page
              d.err = 1'b1;
            end else if (tgt_prot) begin
              d.err = 1'b1;
            end else begin
              d.st   = fimp_pkg::SEQ_ERASE;
              d.busy = 1'b1;
              d.cnt  = {q.tgt[15:7], 7'h00};
              d.last = {q.tgt[15:7], 7'h7F};
            end
          end
        end else if (bus_wr && mode.done && acc_flash) begin
          if (q.ctrl[`FIMP_CTRL_ERASE]) begin
            // a write while erase is armed only picks the page
            d.tgt    = acc_idx;
            d.tgt_ok = 1'b1;
          end else if (q.ctrl[`FIMP_CTRL_PGM]) begin
            if (acc_prot) begin
              d.err = 1'b1;
            end else begin
              // programming can only clear bits
              mem_we = 1'b1;
              mem_wd = acc_rd & bus_wdata;
            end
          end
        end
      end
      fimp_pkg::SEQ_ERASE: begin
        // one byte per clock; port writes are ignored meanwhile
        mem_we   = 1'b1;
        mem_widx = q.cnt;
        mem_wd   = `FIMP_ERASED;
        if (q.cnt == q.last) begin
          d.st     = fimp_pkg::SEQ_IDLE;
          d.busy   = 1'b0;
          d.tgt_ok = 1'b0;
          d.ctrl[`FIMP_CTRL_HVEN] = 1'b0;
        end else begin
          d.cnt = q.cnt + 16'h0001;
        end
      end
      default: begin
        d.st   = fimp_pkg::SEQ_IDLE;
        d.busy = 1'b0;
      end
    endcase

    // read path, registered
    if (bus_rd) begin
      if (ctrl_hit) begin
        d.rdata = {q.busy, q.err, 2'b00, q.ctrl};
      end else if (acc_flash) begin
        d.rdata = acc_rd;
      end else if (rom_hit) begin
        d.rdata = `FIMP_ROM_FILL;
      end else begin
        d.rdata = 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st:     fimp_pkg::SEQ_IDLE,
             ctrl:   `FIMP_CTRL_RESET,
             err:    1'b0,
             busy:   1'b0,
             tgt_ok: 1'b0,
             tgt:    16'h0000,
             cnt:    16'h0000,
             last:   16'h0000,
             rdata:  8'h00,
             baud:   12'h000,
             tick:   1'b0};
    end else begin
      q <= d;
    end
  end

  // nonvolatile: the array is not touched by reset; a plain always
  // because the factory-blank initial block below writes it as well
  always @(posedge core_clk) begin
    if (mem_we) begin
      mem[mem_widx] <= mem_wd;
    end
  end

  // parts leave the factory blank
  initial begin
    for (int i = 0; i < `FIMP_ARRAY_BYTES; i++) begin
      mem[i] = `FIMP_ERASED;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus_rdata        = q.rdata;
  assign flash_busy       = q.busy;
  assign serial_baud_tick = q.tick;
  assign mode_latched     = mode.done;
  assign monitor_mode     = mode.monitor;
  assign hv_entry         = mode.hv_entry;
  assign pll_enable       = mode.pll_en;
  assign port_reset_hold  = mode.port_hold;
  assign latched_straps   = mode.straps;

endmodule

// [hw/fimp_consts.svh]
// Behaviour
// - erase granularity is one 128-byte page at minimum
// - whole-array select bit erases the entire array in one operation
// - an erased byte reads back as 8'hFF until programmed again
// - program and erase are started by writes to the control register; the code programs on the data write to the flash byte once PGM is set
// - protect register selects a region that refuses erase and program
// - protected flash is erasable only in monitor mode
// - protect register lives in flash and is itself protected
// - mode is latched once after reset from irq, reset and port levels
// - raised voltage on irq at reset forces monitor mode
// - raised-voltage monitor derives 9600 baud by dividing the clock
// - blank reset vector at reset also enters monitor mode
// - reset vector bytes are erased only by a whole-array erase
// - blank-vector entry with irq low enables the pll
// - monitor firmware region is fixed; blank array is programmed in monitor
// - in monitor mode the host writes registers and the device obeys
// - blank array at power-up keeps port pins at reset defaults
// - 32 kilobytes of user flash plus 36 bytes of vectors
// - reset vector is the top two bytes; blank when both are 8'hFF
`ifndef FIMP_CONSTS_SVH
`define FIMP_CONSTS_SVH

// ----------------------------------------------------------------
// address map
// ----------------------------------------------------------------
`define FIMP_CTRL_ADDR    16'hFE08
`define FIMP_PROT_ADDR    16'hFF7E
`define FIMP_USER_BASE    16'h7E00
`define FIMP_USER_TOP     16'hFDFF
`define FIMP_VEC_BASE     16'hFFDC
`define FIMP_ROM_BASE     16'hFE20
`define FIMP_ROM_TOP      16'hFF52
`define FIMP_ROM_FILL     8'h00

// ----------------------------------------------------------------
// array geometry, linear byte index
// ----------------------------------------------------------------
`define FIMP_PAGE_BYTES   128
`define FIMP_USER_BYTES   32768
`define FIMP_VEC_BYTES    36
`define FIMP_VEC_IDX      16'h8000
`define FIMP_RVEC_HI_IDX  16'h8022
`define FIMP_RVEC_LO_IDX  16'h8023
`define FIMP_PROT_IDX     16'h8024
`define FIMP_LAST_IDX     16'h8024
`define FIMP_ARRAY_BYTES  32805
`define FIMP_ERASED       8'hFF
`define FIMP_PROT_OFF     8'hFF

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define FIMP_CTRL_PGM     0
`define FIMP_CTRL_ERASE   1
`define FIMP_CTRL_MASS    2
`define FIMP_CTRL_HVEN    3
`define FIMP_CTRL_ERR     6
`define FIMP_CTRL_BUSY    7
`define FIMP_CTRL_RESET   4'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FIMP_CLK_HZ       20000000
`define FIMP_BAUD_RATE    9600
`define FIMP_BAUD_DIV     (`FIMP_CLK_HZ / `FIMP_BAUD_RATE)

`endif

// [hw/fimp_pkg.sv]
package fimp_pkg;

  typedef enum logic [0:0] {
    SEQ_IDLE,
    SEQ_ERASE
  } fimp_seq_e;

  // pin levels sampled at the mode latch point
  typedef struct packed {
    logic irq_high_voltage;
    logic irq_level;
    logic reset_pin_level;
    logic serial_link_pin;
    logic mode_strap_a;
    logic mode_strap_b;
    logic mode_strap_c;
    logic mode_strap_d;
  } fimp_pins_s;

  typedef struct packed {
    logic       done;
    logic       monitor;
    logic       hv_entry;
    logic       pll_en;
    logic       port_hold;
    logic [6:0] straps;
  } fimp_mode_s;

endpackage

// [hw/fimp_mode_latch.sv]
`timescale 1ns/100ps
`include "fimp_consts.svh"

module fimp_mode_latch (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire fimp_pkg::fimp_pins_s pins,
  input  wire logic                 blank_vec,
  output fimp_pkg::fimp_mode_s      mode
);

  fimp_pkg::fimp_mode_s q, d;

  always_comb begin
    d = q;
    // single sample point, frozen until the next reset
    if (!q.done) begin
      d.done      = 1'b1;
      d.hv_entry  = pins.irq_high_voltage;
      d.monitor   = pins.irq_high_voltage | blank_vec;
      // hv entry keeps the pll off; clock comes straight from oscillator
      d.pll_en    = !pins.irq_high_voltage & blank_vec
                    & !pins.irq_level;
      d.port_hold = blank_vec;
      d.straps    = {pins.irq_level, pins.reset_pin_level,
                     pins.serial_link_pin, pins.mode_strap_a,
                     pins.mode_strap_b, pins.mode_strap_c,
                     pins.mode_strap_d};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign mode = q;

endmodule

// [bench/fimp_host_model.sv]
`timescale 1ns/100ps

module fimp_host_model (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        serial_baud_tick,
  output logic             serial_link_pin,
  output logic      [15:0] tick_gap,
  output logic      [7:0]  tick_count
);
  logic [15:0] cnt;

  // line idles at its pull-up level; the host opens no frame here
  assign serial_link_pin = 1'b1;

  // measures bit-time spacing as a host receiver would
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 16'h0000;
      tick_gap <= 16'h0000;
      tick_count <= 8'h00;
    end else if (serial_baud_tick) begin
      tick_gap <= cnt + 16'h0001;
      cnt <= 16'h0000;
      tick_count <= tick_count + 8'h01;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule

// [bench/fimp_flash_ctrl_checker.sv]
`timescale 1ns/100ps

module fimp_flash_ctrl_checker (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [15:0] bus_addr,
  input wire logic        bus_wr,
  input wire logic        irq_high_voltage,
  input wire logic        irq_level,
  input wire logic        reset_pin_level,
  input wire logic        serial_link_pin,
  input wire logic        mode_strap_a,
  input wire logic        mode_strap_b,
  input wire logic        mode_strap_c,
  input wire logic        mode_strap_d,
  input wire logic        mode_latched,
  input wire logic        monitor_mode,
  input wire logic        hv_entry,
  input wire logic        pll_enable,
  input wire logic        port_reset_hold,
  input wire logic [6:0]  latched_straps,
  input wire logic        flash_busy,
  input wire logic        serial_baud_tick
);
  logic [11:0] gap_q;
  logic        seen_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 12'h000;
      seen_q <= 1'b0;
    end else if (serial_baud_tick) begin
      gap_q <= 12'h000;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 12'h001;
    end
  end

  a_latch_prompt: assert property (!mode_latched |=> mode_latched)
    else $error("mode not latched after reset");
  a_latch_holds: assert property (mode_latched |=> mode_latched &&
    $stable(monitor_mode) && $stable(hv_entry) && $stable(pll_enable)
    && $stable(latched_straps))
    else $error("latched mode changed");
  a_straps_sampled: assert property ($rose(mode_latched) |->
    latched_straps == $past({irq_level, reset_pin_level, serial_link_pin,
    mode_strap_a, mode_strap_b, mode_strap_c, mode_strap_d}))
    else $error("straps differ from pins");
  a_hv_sampled: assert property ($rose(mode_latched) |->
    hv_entry == $past(irq_high_voltage) && (!hv_entry || monitor_mode))
    else $error("raised voltage entry wrong");
  a_pll_blank: assert property (pll_enable |-> monitor_mode &&
    !hv_entry && !latched_straps[6])
    else $error("pll enabled outside blank entry");
  a_port_hold: assert property (port_reset_hold |-> monitor_mode)
    else $error("port hold without blank entry");
  a_tick_gated: assert property (serial_baud_tick |->
    monitor_mode && hv_entry)
    else $error("baud tick outside raised entry");
  a_tick_period: assert property (serial_baud_tick && seen_q |->
    gap_q == 12'h822)
    else $error("baud tick spacing wrong");
  a_busy_cause: assert property ($rose(flash_busy) |-> $past(bus_wr) &&
    $past(bus_addr) == 16'hFE08)
    else $error("erase started without control write");

  c_erase_done: cover property ($fell(flash_busy));
  c_tick_pair: cover property (serial_baud_tick && seen_q);
  c_pll_entry: cover property ($rose(mode_latched) ##1 pll_enable);
endmodule

bind fimp_flash_ctrl fimp_flash_ctrl_checker u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
  .irq_high_voltage(irq_high_voltage), .irq_level(irq_level),
  .reset_pin_level(reset_pin_level), .serial_link_pin(serial_link_pin),
  .mode_strap_a(mode_strap_a), .mode_strap_b(mode_strap_b),
  .mode_strap_c(mode_strap_c), .mode_strap_d(mode_strap_d),
  .mode_latched(mode_latched), .monitor_mode(monitor_mode),
  .hv_entry(hv_entry), .pll_enable(pll_enable),
  .port_reset_hold(port_reset_hold), .latched_straps(latched_straps),
  .flash_busy(flash_busy), .serial_baud_tick(serial_baud_tick));

// [bench/fimp_flash_ctrl_bench.sv]
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  errors++; $display("mismatch %s expected %h seen %h", n, e, g); end end

module fimp_flash_ctrl_bench;
  logic                 core_clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic [15:0]          bus_addr = 16'h0000;
  logic                 bus_wr = 1'b0;
  logic                 bus_rd = 1'b0;
  logic [7:0]           bus_wdata = 8'h00;
  logic [7:0]           bus_rdata, rd_q;
  fimp_pkg::fimp_pins_s pin = 8'h35;
  logic                 serial_link_pin, mode_latched, monitor_mode;
  logic                 hv_entry, pll_enable, port_reset_hold;
  logic                 flash_busy, serial_baud_tick;
  logic [6:0]           latched_straps;
  logic [15:0]          tick_gap;
  logic [7:0]           tick_count;
  int                   errors = 0;
  int                   samples_checked = 0;

  // stands for the fixed oscillator the host supplies
  always #25 core_clk = ~core_clk;

  fimp_flash_ctrl dut (.core_clk, .rst_n, .bus_addr, .bus_wr, .bus_rd,
    .bus_wdata, .bus_rdata, .irq_high_voltage(pin.irq_high_voltage),
    .irq_level(pin.irq_level), .reset_pin_level(pin.reset_pin_level),
    .serial_link_pin, .mode_strap_a(pin.mode_strap_a),
    .mode_strap_b(pin.mode_strap_b), .mode_strap_c(pin.mode_strap_c),
    .mode_strap_d(pin.mode_strap_d), .mode_latched, .monitor_mode,
    .hv_entry, .pll_enable, .port_reset_hold, .latched_straps,
    .flash_busy, .serial_baud_tick);

  fimp_host_model host (.core_clk, .rst_n, .serial_baud_tick,
    .serial_link_pin, .tick_gap, .tick_count);

  task automatic complete_run;
    $display("errors %0d checks %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // accesses stand for code run from ram, never from flash
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge core_clk);
    bus_wr = 1'b0;
  endtask

  task automatic chk_rd(input string n, input logic [15:0] a,
                        input logic [7:0] e);
    @(negedge core_clk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge core_clk);
    bus_rd = 1'b0;
    @(negedge core_clk);
    rd_q = bus_rdata;
    `CHK(n, e, rd_q)
  endtask

  task automatic wait_idle;
    int i;
    for (i = 0; i < 40000 && flash_busy !== 1'b0; i++)
      @(negedge core_clk);
    if (flash_busy !== 1'b0) begin
      errors++;
      complete_run;
    end
  endtask

  task automatic erase(input logic [15:0] a, input logic [7:0] go);
    wr(16'hFE08, 8'h02);
    if (go == 8'h0A)
      wr(a, 8'h00);
    wr(16'hFE08, go);
    wait_idle;
  endtask

  task automatic do_reset(input logic hv, input logic lvl);
    @(negedge core_clk);
    rst_n = 1'b0;
    pin.irq_high_voltage = hv;
    pin.irq_level = lvl;
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask

  initial begin
    int i;
    do_reset(1'b0, 1'b0);
    `CHK("monitor", 1'b1, monitor_mode)
    `CHK("pll", 1'b1, pll_enable)
    `CHK("hold", 1'b1, port_reset_hold)
    `CHK("straps", 7'h35, latched_straps)
    wr(16'hFE08, 8'h01);
    wr(16'h7E00, 8'h5A);
    wr(16'h7E00, 8'h0F);
    chk_rd("pgm", 16'h7E00, 8'h0A);
    wr(16'hFFFE, 8'h12);
    wr(16'hFF7E, 8'h01);
    wr(16'h7E80, 8'h00);
    wr(16'hFE20, 8'h55);
    chk_rd("rom", 16'hFE20, 8'h00);
    erase(16'h7E05, 8'h0A);
    chk_rd("page", 16'h7E7F, 8'hFF);
    chk_rd("next", 16'h7E80, 8'h00);
    erase(16'hFFFE, 8'h0A);
    chk_rd("ctrl", 16'hFE08, 8'h4A);
    chk_rd("vec", 16'hFFFE, 8'h12);
    do_reset(1'b0, 1'b0);
    `CHK("user", 1'b0, monitor_mode)
    `CHK("nohold", 1'b0, port_reset_hold)
    wr(16'hFE08, 8'h01);
    wr(16'h7E10, 8'h33);
    chk_rd("free", 16'h7E10, 8'h33);
    wr(16'h7F00, 8'h11);
    chk_rd("ctrl", 16'hFE08, 8'h41);
    chk_rd("prot", 16'h7F00, 8'hFF);
    wr(16'hFE08, 8'h01);
    wr(16'hFF7E, 8'h00);
    chk_rd("pbyte", 16'hFF7E, 8'h01);
    erase(16'h7E80, 8'h0A);
    chk_rd("ctrl", 16'hFE08, 8'h4A);
    chk_rd("kept", 16'h7E80, 8'h00);
    erase(16'h0000, 8'h0E);
    chk_rd("ctrl", 16'hFE08, 8'h4E);
    chk_rd("mass", 16'h7E10, 8'h33);
    do_reset(1'b1, 1'b1);
    `CHK("hv", 1'b1, hv_entry)
    `CHK("hvmon", 1'b1, monitor_mode)
    `CHK("hvpll", 1'b0, pll_enable)
    pin.irq_high_voltage = 1'b0;
    for (i = 0; i < 5000 && tick_count < 8'h02; i++)
      @(negedge core_clk);
    if (tick_count < 8'h02) begin
      errors++;
      complete_run;
    end
    `CHK("gap", 16'h0823, tick_gap)
    erase(16'h0000, 8'h0E);
    chk_rd("mvec", 16'hFFFE, 8'hFF);
    chk_rd("muser", 16'h7E10, 8'hFF);
    chk_rd("mprot", 16'hFF7E, 8'hFF);
    `CHK("still", 1'b1, monitor_mode)
    do_reset(1'b0, 1'b1);
    `CHK("blank", 1'b1, monitor_mode)
    `CHK("nopll", 1'b0, pll_enable)
    complete_run;
  end
endmodule
